// >>> dv/flash_read_monitor.sv
// Concurrent checks on the read engine's APB and link pins
`timescale 1ns/1ns
`default_nettype none
module flash_read_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        select_n,
  input wire logic        serial_clk,
  input wire logic [3:0]  lane_out,
  input wire logic [3:0]  lane_oe_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic mapped = (paddr[1:0] == 2'h0) && (paddr <= 12'h00c);

  sequence access_first;
    psel && penable && !$past(penable);
  endsequence
  sequence long_idle;
    select_n [*6];
  endsequence
  // Lanes move only after the synced fall, so a rise opens a quiet spell
  sequence hold_four;
    ($stable(lane_out) && $stable(lane_oe_n)) [*4];
  endsequence

  apb_wait_a: assert property (access_first |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  err_unmapped_a: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  err_mapped_a: assert property (pready && mapped |-> !pslverr)
    else $error("mapped access refused");
  load_read_a: assert property (pready && !pwrite && paddr == 12'h00c |-> prdata == 32'h0)
    else $error("load data port read not zero");
  lane_release_a: assert property (long_idle |-> lane_oe_n == 4'hf)
    else $error("lanes driven while deselected");
  lane_pattern_a: assert property (lane_oe_n inside {4'hf, 4'hd, 4'hc, 4'h0})
    else $error("illegal lane drive pattern");
  data_hold_a: assert property ($rose(serial_clk) |=> hold_four)
    else $error("lanes changed after a rising link edge");
endmodule // flash_read_monitor

bind flash_read_engine flash_read_monitor u_flash_read_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .select_n(select_n),
  .serial_clk(serial_clk), .lane_out(lane_out), .lane_oe_n(lane_oe_n));
`default_nettype wire

// >>> dv/spi_host_model.sv
// Host-side serial flash controller model for the read engine's link pins
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
  output logic            select_n,
  output logic            serial_clk,
  output logic      [3:0] lane_in,
  input  wire logic [3:0] lane_out,
  input  wire logic [3:0] lane_oe_n
);
  logic [3:0] host_val;
  logic [3:0] host_oe_n;
  logic [3:0] rel_val;
  logic [7:0] rx_byte;
  logic       drove;
  event       rx_ev;

  initial begin
    select_n = 1'b1;
    serial_clk = 1'b0;  // Parked low between frames
    host_val = 4'h0;
    host_oe_n = 4'hf;
    rel_val = 4'h5;
    drove = 1'b0;
  end

  // No pull-ups: a released lane flips every clock
  always_comb
    for (int i = 0; i < 4; i++)
      lane_in[i] = !lane_oe_n[i] ? lane_out[i] : !host_oe_n[i] ? host_val[i] : rel_val[i];

  task automatic shift(input logic [3:0] v, input logic [3:0] oe_n, output logic [3:0] g);
    host_val = v;
    host_oe_n = oe_n;
    rel_val = ~rel_val;
    #24;
    serial_clk = 1'b1;
    g = lane_in;
    if (lane_oe_n != 4'hf)
      drove = 1'b1;
    #24;
    serial_clk = 1'b0;
  endtask

  task automatic send(input logic [31:0] v, input int nbits, input int w);
    logic [3:0] g;
    logic [3:0] m;
    m = (w == 4) ? 4'h0 : (w == 2) ? 4'hc : 4'he;
    for (int i = nbits - w; i >= 0; i -= w)
      shift(4'((v >> i) & ((1 << w) - 1)), m, g);
  endtask

  task automatic frame(input logic [7:0] op, input logic [23:0] ad, input logic [7:0] mode,
                       input int aw, input int dw, input int dum, input int n, input bit skip);
    logic [3:0] g;
    logic [7:0] b;
    b = 8'h0;
    drove = 1'b0;
    select_n = 1'b0;
    #30;
    if (!skip)
      send({24'h0, op}, 8, 1);
    send({8'h0, ad}, 24, aw);
    if (aw > 1)
      send({24'h0, mode}, 8, aw);
    repeat (dum) shift(4'h0, 4'hf, g);
    for (int k = 0; k < n; k++) begin
      for (int j = 0; j < 8 / dw; j++) begin
        shift(4'h0, 4'hf, g);
        b = (dw == 1) ? {b[6:0], g[1]} : (dw == 2) ? {b[5:0], g[1:0]} : {b[3:0], g};
      end
      rx_byte = b;
      -> rx_ev;
    end
    #30;
    select_n = 1'b1;
    #60;
  endtask

  // All ones on every lane ends the opcode-free mode
  task automatic release_cont(input int nclk);
    logic [3:0] g;
    select_n = 1'b0;
    #30;
    repeat (nclk) shift(4'hf, 4'h0, g);
    #30;
    select_n = 1'b1;
    #60;
  endtask
endmodule // spi_host_model
`default_nettype wire

// >>> dv/tb_flash_read_engine.sv
// Self-checking bench for the multi-lane flash read engine
`timescale 1ns/1ns
`default_nettype none
module tb_flash_read_engine;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        select_n;
  logic        serial_clk;
  logic [3:0]  lane_in;
  logic [3:0]  lane_out;
  logic [3:0]  lane_oe_n;
  logic [7:0]  mem [256];
  logic [31:0] word_q[$];
  logic [7:0]  byte_q[$];
  logic [23:0] a;
  int          err_count;
  int          checks;
  int          seed;
  bit          listen;

  flash_read_engine #(.MEM_AW(8)) u_flash_read_engine (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .select_n(select_n), .serial_clk(serial_clk), .lane_in(lane_in), .lane_out(lane_out),
    .lane_oe_n(lane_oe_n));
  spi_host_model u_spi_host_model (
    .select_n(select_n), .serial_clk(serial_clk), .lane_in(lane_in), .lane_out(lane_out),
    .lane_oe_n(lane_oe_n));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic check_word(input string what, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic check_byte(input string what, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask

  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
      check_word("prdata", word_q.pop_front(), prdata);
  always @(u_spi_host_model.rx_ev)
    if (listen)
      check_byte("lane byte", byte_q.pop_front(), u_spi_host_model.rx_byte);

  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d,
                     input logic [31:0] e);
    @(posedge pclk);
    if (!wr)
      word_q.push_back(e);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Wrap keeps the page-relative section, len 0 means a plain increment
  function automatic logic [7:0] exp_b(input logic [23:0] ad, input int n, input int len);
    logic [23:0] p;
    p = (len == 0) ? ad + 24'(n) : (ad & ~24'(len - 1)) | ((ad + 24'(n)) & 24'(len - 1));
    return mem[p[7:0]];
  endfunction

  task automatic rd(input logic [7:0] op, input int aw, input int dw, input int dum,
                    input logic [7:0] mode, input bit skip, input int n, input int len,
                    input bit ok);
    a = 24'($random(seed));
    if (op == flash_read_pkg::OP_WORD_QUAD)
      a[0] = 1'b0;
    listen = ok;
    for (int i = 0; i < n && ok; i++)
      byte_q.push_back(exp_b(a, i, len));
    // Link pins move off pclk edges
    @(negedge pclk) #1 u_spi_host_model.frame(op, a, mode, aw, dw, dum, n, skip);
    listen = 1'b1;
    check_byte("drive flag", {7'h0, ok}, {7'h0, u_spi_host_model.drove});
  endtask

  task automatic results;
    $display("errors %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #300000;
    err_count++;
    results;
  end

  initial begin
    seed = 28;
    listen = 1'b1;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, flash_read_pkg::OFS_CTRL, 32'h0, 32'h2);
    apb(1'b1, flash_read_pkg::OFS_STATUS, 32'hffff, 32'h0);
    apb(1'b0, flash_read_pkg::OFS_STATUS, 32'h0, 32'h0);
    apb(1'b0, 12'h010, 32'h0, 32'h0);
    apb(1'b1, flash_read_pkg::OFS_LOAD_ADDR, 32'h0, 32'h0);
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'($random(seed));
      apb(1'b1, flash_read_pkg::OFS_LOAD_DATA, {24'h0, mem[i]}, 32'h0);
    end
    apb(1'b0, flash_read_pkg::OFS_LOAD_DATA, 32'h0, 32'h0);
    rd(flash_read_pkg::OP_FAST, 1, 1, 8, 8'h0, 1'b0, 4, 0, 1'b1);
    rd(flash_read_pkg::OP_DUAL_OUT, 1, 2, 8, 8'h0, 1'b0, 4, 0, 1'b1);
    rd(flash_read_pkg::OP_QUAD_OUT, 1, 4, 8, 8'h0, 1'b0, 2, 0, 1'b0);
    rd(flash_read_pkg::OP_QUAD_IO, 4, 4, 4, 8'h0, 1'b0, 2, 0, 1'b0);
    rd(flash_read_pkg::OP_WORD_QUAD, 4, 4, 2, 8'h0, 1'b0, 2, 0, 1'b0);
    apb(1'b1, flash_read_pkg::OFS_CTRL, 32'h3, 32'h0);
    apb(1'b0, flash_read_pkg::OFS_CTRL, 32'h0, 32'h3);
    rd(flash_read_pkg::OP_QUAD_OUT, 1, 4, 8, 8'h0, 1'b0, 4, 0, 1'b1);
    rd(flash_read_pkg::OP_DUAL_IO, 2, 2, 0, 8'h2f, 1'b0, 4, 0, 1'b1);
    rd(flash_read_pkg::OP_DUAL_IO, 2, 2, 0, 8'hd0, 1'b1, 4, 0, 1'b1);
    rd(flash_read_pkg::OP_FAST, 1, 1, 8, 8'h0, 1'b0, 2, 0, 1'b1);
    rd(flash_read_pkg::OP_QUAD_IO, 4, 4, 4, 8'ha5, 1'b0, 4, 0, 1'b1);
    rd(flash_read_pkg::OP_QUAD_IO, 4, 4, 4, 8'h00, 1'b1, 4, 0, 1'b1);
    rd(flash_read_pkg::OP_WORD_QUAD, 4, 4, 2, 8'h2f, 1'b0, 4, 0, 1'b1);
    @(negedge pclk) #1 u_spi_host_model.release_cont(8);
    rd(flash_read_pkg::OP_FAST, 1, 1, 8, 8'h0, 1'b0, 2, 0, 1'b1);
    rd(flash_read_pkg::OP_DUAL_IO, 2, 2, 0, 8'h20, 1'b0, 2, 0, 1'b1);
    @(negedge pclk) #1 u_spi_host_model.release_cont(16);
    rd(flash_read_pkg::OP_FAST, 1, 1, 8, 8'h0, 1'b0, 2, 0, 1'b1);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, flash_read_pkg::OFS_CTRL, {28'h0, 2'(s), 2'b01}, 32'h0);
      rd(flash_read_pkg::OP_QUAD_IO, 4, 4, 4, 8'h0, 1'b0, (8 << s) + 3, 8 << s, 1'b1);
    end
    rd(flash_read_pkg::OP_WORD_QUAD, 4, 4, 2, 8'h0, 1'b0, 67, 64, 1'b1);
    rd(flash_read_pkg::OP_FAST, 1, 1, 8, 8'h0, 1'b0, 6, 0, 1'b1);
    results;
  end
endmodule // tb_flash_read_engine
`default_nettype wire

// >>> hdl/flash_array.sv
// Byte array holding the flash contents, registered read port
`timescale 1ns/1ns
`default_nettype none
module flash_array #(
  parameter int AW = 12
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata
);
  logic [7:0] mem [0:(1<<AW)-1];
  logic [7:0] rdata_nxt;

  always_comb begin
    rdata_nxt = mem[raddr];
  end

  // Array has no reset; contents come only from software loads
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rdata_nxt;
    end
  end
endmodule // flash_array
`default_nettype wire

// >>> hdl/flash_read_engine.sv
// Device-side multi-lane read command engine with APB control registers
//
// Summary of operation
// - Fast read: opcode, 24-bit address, eight dummy clocks, then serial data out.
// - Output lane level during dummy clocks is meaningless; lanes stay undriven.
// - Dual-output read: single-lane address, eight dummies, data on lanes zero and one.
// - Quad-output read: single-lane address, eight dummies, data on all four lanes.
// - Quad-output read accepted only while quad_lane_permit is one.
// - Dual address/data read: address and data two bits per clock.
// - Mode byte follows address in multi-lane address reads; upper nibble matters only.
// - repeat_select_pair 10 lets next dual read skip opcode; else normal decoding.
// - Same opcode skip for quad address/data read.
// - Same opcode skip for word quad read.
// - Quad address/data read: four bits per clock, four dummies before data.
// - Quad address/data read honoured only while quad_lane_permit is set.
// - With wrap enabled quad address/data and word quad reads wrap inside 8/16/32/64-byte section.
// - Wrap setting: wrap_disable_bit plus two-bit wrap_length_sel.
// - Word quad read: host gives even address; two dummy clocks.
// - Word quad read honoured only while quad_lane_permit is set.
// - Inputs sampled on rising clock; data MSB first on falling; address increments.
// - Length codes 00..11 give 8..64 bytes; wrap_disable_bit resets to one.
// - All-ones mode bits release continuous read: eight quad, sixteen dual clocks.
`timescale 1ns/1ns
`default_nettype none
module flash_read_engine #(
  parameter int MEM_AW = 12
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        select_n,
  input  wire logic        serial_clk,
  input  wire logic [3:0]  lane_in,
  output logic      [3:0]  lane_out,
  output logic      [3:0]  lane_oe_n
);

  if (MEM_AW < 8 || MEM_AW > 24) begin : g_bad_aw
    $error("MEM_AW must lie between 8 and 24");
  end

  // Pin synchronisation; the edge detector reads only the second stage
  logic [5:0] pins_s;
  logic       sel_n_s;
  logic       sck_s;
  logic [3:0] lanes_s;

  pin_sync #(.W(6)) u_sync (
    .clk     (pclk),
    .rst_n   (presetn),
    .d       ({select_n, serial_clk, lane_in}),
    .rst_val (6'h3f),
    .q       (pins_s)
  );

  always_comb begin
    sel_n_s = pins_s[5];
    sck_s   = pins_s[4];
    lanes_s = pins_s[3:0];
  end

  logic sck_d_r, sck_d_nxt;
  logic sel_d_r, sel_d_nxt;
  logic sck_rise, sck_fall, frame_start, frame_end;

  always_comb begin
    sck_d_nxt   = sck_s;
    sel_d_nxt   = sel_n_s;
    sck_rise    = !sel_n_s && sck_s && !sck_d_r;
    sck_fall    = !sel_n_s && !sck_s && sck_d_r;
    frame_start = sel_d_r && !sel_n_s;
    frame_end   = !sel_d_r && sel_n_s;
  end

  // APB register state
  logic                qe_r, qe_nxt;
  flash_read_pkg::wrap_cfg_t wrap_r, wrap_nxt;
  logic [23:0]         load_addr_r, load_addr_nxt;
  logic [31:0]         prdata_nxt;
  logic                pready_nxt, pslverr_nxt;
  logic                apb_setup, apb_done, apb_hit;
  logic                mem_we;

  // Link state
  flash_read_pkg::link_state_t state_r, state_nxt;
  flash_read_pkg::cmd_prof_t   prof_r, prof_nxt, prof_dec;
  logic [4:0]  cnt_r, cnt_nxt;
  logic [23:0] sh_r, sh_nxt, sh_in;
  logic [23:0] addr_r, addr_nxt;
  logic [7:0]  opcode_r, opcode_nxt;
  logic        cont_r, cont_nxt;
  logic [7:0]  out_sh_r, out_sh_nxt, byte_v;
  logic [3:0]  bits_left_r, bits_left_nxt, bits_avail;
  logic [3:0]  lane_out_nxt, lane_oe_n_nxt;
  logic [7:0]  mem_q;
  logic [2:0]  in_w;
  logic [4:0]  phase_len;

  // Section wrap inside a page when enabled and the command allows it
  function automatic logic [23:0] next_addr(input logic [23:0] a, input logic wrap_en,
                                            input logic [1:0] len_sel);
    logic [23:0] mask;
    logic [23:0] inc;
    mask = (24'h000008 << len_sel) - 24'h000001;
    inc  = a + 24'h000001;
    if (wrap_en) begin
      return (a & ~mask) | (inc & mask);
    end
    return inc;
  endfunction

  function automatic logic [31:0] reg_read(input logic [11:0] ofs, input logic qe,
                                           input flash_read_pkg::wrap_cfg_t w,
                                           input logic [23:0] la, input logic cont,
                                           input logic busy, input logic [7:0] op);
    case (ofs)
      flash_read_pkg::OFS_CTRL:      return {28'h0, w.wrap_length_sel, w.wrap_disable_bit, qe};
      flash_read_pkg::OFS_STATUS:    return {16'h0, op, 6'h0, busy, cont};
      flash_read_pkg::OFS_LOAD_ADDR: return {8'h0, la};
      default:                       return 32'h0;
    endcase
  endfunction

  always_comb begin
    apb_setup = psel && penable && !pready;
    apb_done  = psel && penable && pready;
    apb_hit   = (paddr == flash_read_pkg::OFS_CTRL) || (paddr == flash_read_pkg::OFS_STATUS)
             || (paddr == flash_read_pkg::OFS_LOAD_ADDR)
             || (paddr == flash_read_pkg::OFS_LOAD_DATA);
    pready_nxt    = apb_setup;
    pslverr_nxt   = apb_setup && !apb_hit;
    prdata_nxt    = prdata;
    qe_nxt        = qe_r;
    wrap_nxt      = wrap_r;
    load_addr_nxt = load_addr_r;
    mem_we        = 1'b0;
    if (apb_setup) begin
      prdata_nxt = pwrite ? 32'h0
                 : reg_read(paddr, qe_r, wrap_r, load_addr_r, cont_r, !sel_n_s, opcode_r);
    end
    // Writes land only at the edge that completes the access
    if (apb_done && pwrite) begin
      case (paddr)
        flash_read_pkg::OFS_CTRL: begin
          qe_nxt                    = pwdata[0];
          wrap_nxt.wrap_disable_bit = pwdata[1];
          wrap_nxt.wrap_length_sel  = pwdata[3:2];
        end
        flash_read_pkg::OFS_LOAD_ADDR: load_addr_nxt = pwdata[23:0];
        flash_read_pkg::OFS_LOAD_DATA: begin
          mem_we        = 1'b1;
          load_addr_nxt = load_addr_r + 24'h000001;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qe_r                    <= flash_read_pkg::QE_RESET;
      wrap_r.wrap_disable_bit <= flash_read_pkg::WRAP_DIS_RST;
      wrap_r.wrap_length_sel  <= flash_read_pkg::WRAP_LEN_RST;
      load_addr_r             <= 24'h000000;
      prdata                  <= 32'h0;
      pready                  <= 1'b0;
      pslverr                 <= 1'b0;
    end else begin
      qe_r        <= qe_nxt;
      wrap_r      <= wrap_nxt;
      load_addr_r <= load_addr_nxt;
      prdata      <= prdata_nxt;
      pready      <= pready_nxt;
      pslverr     <= pslverr_nxt;
    end
  end

  flash_array #(.AW(MEM_AW)) u_array (
    .clk   (pclk),
    .rst_n (presetn),
    .we    (mem_we),
    .waddr (load_addr_r[MEM_AW-1:0]),
    .wdata (pwdata[7:0]),
    .raddr (addr_r[MEM_AW-1:0]),
    .rdata (mem_q)
  );

  // Link sequencer
  always_comb begin
    state_nxt     = state_r;
    prof_nxt      = prof_r;
    cnt_nxt       = cnt_r;
    sh_nxt        = sh_r;
    addr_nxt      = addr_r;
    opcode_nxt    = opcode_r;
    cont_nxt      = cont_r;
    out_sh_nxt    = out_sh_r;
    bits_left_nxt = bits_left_r;
    lane_out_nxt  = lane_out;
    lane_oe_n_nxt = lane_oe_n;
    in_w          = (state_r == flash_read_pkg::ST_OPCODE) ? flash_read_pkg::LANES_1
                  : prof_r.addr_w;
    sh_in         = flash_read_pkg::shift_in(sh_r, lanes_s, in_w);
    phase_len     = (state_r == flash_read_pkg::ST_MODE)
                  ? flash_read_pkg::phase_clocks(flash_read_pkg::MODE_BITS, in_w)
                  : flash_read_pkg::phase_clocks(flash_read_pkg::ADDR_BITS, in_w);
    prof_dec      = flash_read_pkg::cmd_decode(sh_in[7:0], qe_r);
    bits_avail    = (bits_left_r == 4'h0) ? flash_read_pkg::BYTE_BITS : bits_left_r;
    byte_v        = (bits_left_r == 4'h0) ? mem_q : out_sh_r;
    if (frame_end || sel_n_s) begin
      state_nxt     = flash_read_pkg::ST_IDLE;
      lane_oe_n_nxt = 4'hf;
    end else if (frame_start) begin
      cnt_nxt     = 5'h00;
      bits_left_nxt = 4'h0;
      // Continuous read goes straight to the address with the kept profile
      state_nxt   = cont_r ? flash_read_pkg::ST_ADDR : flash_read_pkg::ST_OPCODE;
    end else if (sck_rise) begin
      unique case (state_r)
        flash_read_pkg::ST_OPCODE: begin
          sh_nxt  = sh_in;
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == flash_read_pkg::OPCODE_BITS - 5'h01) begin
            cnt_nxt    = 5'h00;
            opcode_nxt = sh_in[7:0];
            prof_nxt   = prof_dec;
            // Unknown opcode, or quad opcode without permission, is ignored
            state_nxt  = prof_dec.valid ? flash_read_pkg::ST_ADDR
                       : flash_read_pkg::ST_IGNORE;
          end
        end
        flash_read_pkg::ST_ADDR: begin
          sh_nxt  = sh_in;
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == phase_len - 5'h01) begin
            cnt_nxt  = 5'h00;
            addr_nxt = sh_in;
            if (prof_r.has_mode) begin
              state_nxt = flash_read_pkg::ST_MODE;
            end else if (prof_r.dummy != 4'h0) begin
              state_nxt = flash_read_pkg::ST_DUMMY;
            end else begin
              state_nxt = flash_read_pkg::ST_DATA;
            end
          end
        end
        flash_read_pkg::ST_MODE: begin
          sh_nxt  = sh_in;
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == phase_len - 5'h01) begin
            cnt_nxt   = 5'h00;
            // Only the pair decides; an all-ones byte also releases the mode
            cont_nxt  = (sh_in[5:4] == flash_read_pkg::REPEAT_KEEP);
            state_nxt = (prof_r.dummy != 4'h0) ? flash_read_pkg::ST_DUMMY
                      : flash_read_pkg::ST_DATA;
          end
        end
        flash_read_pkg::ST_DUMMY: begin
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == {1'b0, prof_r.dummy} - 5'h01) begin
            cnt_nxt   = 5'h00;
            state_nxt = flash_read_pkg::ST_DATA;
          end
        end
        default: ;
      endcase
    end else if (sck_fall && state_r == flash_read_pkg::ST_DATA) begin
      // MSB first; a new byte is taken from the array when the last one is spent
      out_sh_nxt    = byte_v << prof_r.data_w;
      bits_left_nxt = bits_avail - {1'b0, prof_r.data_w};
      if (bits_left_r == 4'h0) begin
        addr_nxt = next_addr(addr_r, prof_r.wraps && !wrap_r.wrap_disable_bit,
                             wrap_r.wrap_length_sel);
      end
      unique case (prof_r.data_w)
        flash_read_pkg::LANES_2: begin
          lane_out_nxt  = {2'b00, byte_v[7:6]};
          lane_oe_n_nxt = 4'hc;
        end
        flash_read_pkg::LANES_4: begin
          lane_out_nxt  = byte_v[7:4];
          lane_oe_n_nxt = 4'h0;
        end
        default: begin
          lane_out_nxt  = {2'b00, byte_v[7], 1'b0};
          lane_oe_n_nxt = 4'hd;
        end
      endcase
    end
    if (state_r != flash_read_pkg::ST_DATA) begin
      lane_oe_n_nxt = 4'hf;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_d_r     <= 1'b1;
      sel_d_r     <= 1'b1;
      state_r     <= flash_read_pkg::ST_IDLE;
      prof_r      <= '0;
      cnt_r       <= 5'h00;
      sh_r        <= 24'h000000;
      addr_r      <= 24'h000000;
      opcode_r    <= 8'h00;
      cont_r      <= 1'b0;
      out_sh_r    <= 8'h00;
      bits_left_r <= 4'h0;
      lane_out    <= 4'h0;
      lane_oe_n   <= 4'hf;
    end else begin
      sck_d_r     <= sck_d_nxt;
      sel_d_r     <= sel_d_nxt;
      state_r     <= state_nxt;
      prof_r      <= prof_nxt;
      cnt_r       <= cnt_nxt;
      sh_r        <= sh_nxt;
      addr_r      <= addr_nxt;
      opcode_r    <= opcode_nxt;
      cont_r      <= cont_nxt;
      out_sh_r    <= out_sh_nxt;
      bits_left_r <= bits_left_nxt;
      lane_out    <= lane_out_nxt;
      lane_oe_n   <= lane_oe_n_nxt;
    end
  end

endmodule // flash_read_engine
`default_nettype wire

// >>> hdl/flash_read_pkg.sv
// Shared constants, types and decode functions for the multi-lane read engine
package flash_read_pkg;

  localparam logic [7:0]  OP_FAST       = 8'h0b;
  localparam logic [7:0]  OP_DUAL_OUT   = 8'h3b;
  localparam logic [7:0]  OP_QUAD_OUT   = 8'h6b;
  localparam logic [7:0]  OP_DUAL_IO    = 8'hbb;
  localparam logic [7:0]  OP_QUAD_IO    = 8'heb;
  localparam logic [7:0]  OP_WORD_QUAD  = 8'he7;

  localparam logic [2:0]  LANES_1       = 3'h1;
  localparam logic [2:0]  LANES_2       = 3'h2;
  localparam logic [2:0]  LANES_4       = 3'h4;
  localparam logic [4:0]  OPCODE_BITS   = 5'h08;
  localparam logic [4:0]  ADDR_BITS     = 5'h18;
  localparam logic [4:0]  MODE_BITS     = 5'h08;
  localparam logic [3:0]  DUMMY_FAST    = 4'h8;
  localparam logic [3:0]  DUMMY_QUAD_IO = 4'h4;
  localparam logic [3:0]  DUMMY_WORD    = 4'h2;
  localparam logic [3:0]  DUMMY_NONE    = 4'h0;
  localparam logic [1:0]  REPEAT_KEEP   = 2'h2;
  localparam logic [3:0]  BYTE_BITS     = 4'h8;

  localparam logic [11:0] OFS_CTRL      = 12'h000;
  localparam logic [11:0] OFS_STATUS    = 12'h004;
  localparam logic [11:0] OFS_LOAD_ADDR = 12'h008;
  localparam logic [11:0] OFS_LOAD_DATA = 12'h00c;
  localparam logic        QE_RESET      = 1'b0;
  localparam logic        WRAP_DIS_RST  = 1'b1;
  localparam logic [1:0]  WRAP_LEN_RST  = 2'h0;

  typedef enum logic [2:0] {
    ST_IDLE, ST_OPCODE, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_IGNORE
  } link_state_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] addr_w;
    logic       has_mode;
    logic [3:0] dummy;
    logic [2:0] data_w;
    logic       wraps;
  } cmd_prof_t;

  typedef struct packed {
    logic       wrap_disable_bit;
    logic [1:0] wrap_length_sel;
  } wrap_cfg_t;

  function automatic cmd_prof_t cmd_decode(input logic [7:0] op, input logic qe);
    cmd_prof_t p;
    p = '0;
    p.addr_w = LANES_1;
    p.data_w = LANES_1;
    p.dummy  = DUMMY_FAST;
    case (op)
      OP_FAST:      p.valid = 1'b1;
      OP_DUAL_OUT: begin
        p.valid  = 1'b1;
        p.data_w = LANES_2;
      end
      OP_QUAD_OUT: begin
        p.valid  = qe;
        p.data_w = LANES_4;
      end
      OP_DUAL_IO: begin
        p.valid    = 1'b1;
        p.addr_w   = LANES_2;
        p.data_w   = LANES_2;
        p.has_mode = 1'b1;
        p.dummy    = DUMMY_NONE;
      end
      OP_QUAD_IO: begin
        p.valid    = qe;
        p.addr_w   = LANES_4;
        p.data_w   = LANES_4;
        p.has_mode = 1'b1;
        p.dummy    = DUMMY_QUAD_IO;
        p.wraps    = 1'b1;
      end
      OP_WORD_QUAD: begin
        p.valid    = qe;
        p.addr_w   = LANES_4;
        p.data_w   = LANES_4;
        p.has_mode = 1'b1;
        p.dummy    = DUMMY_WORD;
        p.wraps    = 1'b1;
      end
      default:      p.valid = 1'b0;
    endcase
    return p;
  endfunction

  // Clocks needed to move a field of the given bit count over w lanes
  function automatic logic [4:0] phase_clocks(input logic [4:0] bits, input logic [2:0] w);
    case (w)
      LANES_2: return bits >> 1;
      LANES_4: return bits >> 2;
      default: return bits;
    endcase
  endfunction

  function automatic logic [23:0] shift_in(input logic [23:0] acc, input logic [3:0] ln,
                                           input logic [2:0] w);
    case (w)
      LANES_2: return {acc[21:0], ln[1:0]};
      LANES_4: return {acc[19:0], ln};
      default: return {acc[22:0], ln[0]};
    endcase
  endfunction

endpackage

// >>> hdl/pin_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  // Reset to all ones; callers that need other idle levels invert around it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '1;
      q      <= '1;
    end else begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end
endmodule // pin_sync
`default_nettype wire
